/* File: hw/sensor_node_pkg.sv */
// constants, frame layout and types for the sensor bus node slave logic
// assumes a 125 MHz pclk and a bit-level phy that frames the bus words
//
// Function
// RULE1: response flags upstream pin shorted to battery (code sends the fault flag held before the test, always zero at an init)
// RULE2: group bits in response always zero
// RULE3: response returns stored nvm write permit bit
// RULE4: response carries switch close request bit
// RULE5: response returns programmed address plus own check
// RULE6: response shifts out while command shifts in
// RULE7: response goes out during the next message
// RULE8: master keeps minimum frame delay between words
// RULE9: corrupted frame means no response next frame
// RULE10: master resends same-size command after check error
// RULE11: master reissues following command to resynchronise
// RULE12: master waits for holdup capacitor charge
// RULE13: master waits for next chained node power-up
// RULE14: fault test runs once when switch requested
// RULE15: pull-down inactive side, fault if stays high
// RULE16: fault test lasts about 200 microseconds
// RULE17: switch closes only when no fault found
// RULE18: downstream tested forward, upstream tested reverse
// RULE19: no fault test in loop-back chain
// RULE20: global address init sets zero, switch open
// RULE21: global init ignores nvm and switch bits
// RULE22: at address zero execute but never respond
// RULE23: global init blocks re-init until cleared
// RULE24: no short-word response to reverse init
// RULE25: reverse-initialised node ignores further inits
// RULE26: four-bit check code over word, mismatch corrupt
package sensor_node_pkg;

   // ==========================================================
   // frame layout (word lengths in bits and check code constants)
   localparam int        LONG_BITS      = 20;
   localparam int        SHORT_BITS     = 12;
   localparam logic [4:0] LONG_BITS_W   = 5'h14;
   localparam logic [4:0] SHORT_BITS_W  = 5'h0C;
   localparam logic [3:0] CRC_POLY      = 4'h3;
   localparam logic [3:0] CRC_SEED      = 4'hA;

   // ==========================================================
   // command codes and the global address
   localparam logic [3:0] CMD_RINIT     = 4'hF;
   localparam logic [3:0] CMD_INIT      = 4'h0;
   localparam logic [3:0] CMD_CLEAR     = 4'h1;
   localparam logic [3:0] GLOBAL_ADDR   = 4'h0;

   // ==========================================================
   // fault test timing
   localparam int        CLK_PERIOD_NS  = 8;
   localparam int        TEST_TIME_US   = 200;
   localparam int        TEST_CYC_DEF   = TEST_TIME_US * 1000 / CLK_PERIOD_NS;

   // ==========================================================
   // register map (byte offsets) and fields
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_STATUS    = 8'h04;
   localparam logic [7:0] OFS_LASTCMD   = 8'h08;
   localparam logic [7:0] OFS_ERRCNT    = 8'h0C;
   localparam int        CTRL_EN_BIT    = 0;
   localparam int        CTRL_LOOP_BIT  = 1;
   localparam int        CTRL_CLR_BIT   = 2;
   localparam logic      CTRL_EN_RST    = 1'b1;
   localparam logic      CTRL_LOOP_RST  = 1'b0;

   typedef enum logic [0:0] {TST_IDLE, TST_RUN} test_st_t;

endpackage

/* File: hw/sensor_node.sv */
// slave logic of one node on the two-wire sensor bus: word framing,
// initialisation handling, response build and the bus fault test
// assumes a phy on pclk that gives frame and bit strobes, and analog
// comparators on both bus pins that arrive asynchronously
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
module sensor_node
#(
   parameter int unsigned TEST_CYCLES = sensor_node_pkg::TEST_CYC_DEF
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        frame_start,
   input  wire logic        frame_long,
   input  wire logic        bit_strobe,
   input  wire logic        rx_bit,
   input  wire logic        frame_end,
   output logic             tx_bit,
   output logic             tx_en,
   input  wire logic        upstream_bus_pin_high,
   input  wire logic        downstream_bus_pin_high,
   output logic             upstream_pulldown_en,
   output logic             downstream_pulldown_en,
   output logic             bus_switch_close,
   output logic             bus_fault_flag,
   output logic             nvm_write_permit,
   output logic [3:0]       programmed_bus_address,
   output logic             cmd_strobe,
   output logic [3:0]       cmd_code,
   output logic [7:0]       cmd_data
);
   import sensor_node_pkg::*;

   typedef struct packed {
      test_st_t    tst;
      logic [15:0] tcnt;
      logic        tside;
      logic [3:0]  addr;
      logic        nv;
      logic        bs;
      logic        bf;
      logic        sw;
      logic        locked;
      logic        gzero;
      logic [19:0] rx_sh;
      logic [4:0]  nbits;
      logic [19:0] tx_sh;
      logic        tx_on;
      logic [19:0] pend;
      logic        pend_valid;
      logic        pend_long_only;
      logic [2:0]  up_s;
      logic        up_f;
      logic [2:0]  dn_s;
      logic        dn_f;
      logic        ctrl_en;
      logic        ctrl_loop;
      logic [31:0] prdata;
      logic [15:0] err_cnt;
      logic [19:0] last_cmd;
      logic        cmd_stb;
      logic [3:0]  cmd_code;
      logic [7:0]  cmd_data;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // ==========================================================
   // check code, msb first; short words use only the low byte
   function automatic logic [3:0] crc_calc(input logic [15:0] d,
                                           input logic        lng);
      logic [3:0] c;
      logic       fb;
      c = CRC_SEED;
      for (int i = 15; i >= 0; i--)
      begin
         if (lng || i < 8)
         begin
            fb = c[3] ^ d[i];
            c  = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
         end
      end
      return c;
   endfunction

   // ==========================================================
   // decode of a finished command frame
   logic        is_long;
   logic        is_short;
   logic        crc_ok;
   logic        bad_frame;
   logic        good_frame;
   logic [3:0]  f_cmd;
   logic [3:0]  f_addr;
   logic [7:0]  f_data;
   logic [3:0]  f_pa;
   logic        is_init;
   logic        init_hit;
   logic        global_hit;
   logic        clear_hit;
   logic        other_hit;
   logic [15:0] resp_body;
   logic [19:0] resp_word;
   logic        test_done;
   logic        apb_setup;
   logic        apb_wr;
   logic        addr_ok;

   assign is_long    = st_r.nbits == LONG_BITS_W;
   assign is_short   = st_r.nbits == SHORT_BITS_W;
   assign f_cmd      = st_r.rx_sh[7:4];
   assign f_addr     = st_r.rx_sh[11:8];
   assign f_data     = st_r.rx_sh[19:12];
   assign f_pa       = f_data[3:0];
   assign crc_ok     = crc_calc(st_r.rx_sh[19:4], is_long)
                       == st_r.rx_sh[3:0]; // RULE26
   assign bad_frame  = frame_end && st_r.ctrl_en
                       && (!(is_long || is_short) || !crc_ok); // RULE26
   assign good_frame = frame_end && st_r.ctrl_en && !bad_frame;
   assign is_init    = f_cmd == CMD_INIT || f_cmd == CMD_RINIT;
   // inits are long-word only and only taken once until cleared
   assign init_hit   = good_frame && is_long && is_init && !st_r.locked
                       && f_addr == st_r.addr; // RULE23 RULE25
   assign global_hit = init_hit && f_pa == GLOBAL_ADDR; // RULE20
   assign clear_hit  = good_frame && f_cmd == CMD_CLEAR
                       && f_addr == st_r.addr;
   assign other_hit  = good_frame && !is_init && f_cmd != CMD_CLEAR
                       && f_addr == st_r.addr;

   // response to an init: address, fault, permit, switch request,
   // zero group bits, programmed address, own check code
   assign resp_body  = {f_pa, 3'h0, st_r.bf, f_data[7], f_data[6],
                        2'h0, f_pa}; // RULE1 RULE2 RULE3 RULE4 RULE5
   assign resp_word  = {resp_body, crc_calc(resp_body, 1'b1)}; // RULE5

   assign test_done  = st_r.tst == TST_RUN
                       && st_r.tcnt == 16'(TEST_CYCLES - 1); // RULE16

   assign apb_setup  = psel && !penable;
   assign apb_wr     = psel && penable && pwrite;
   assign addr_ok    = paddr == OFS_CTRL || paddr == OFS_STATUS
                       || paddr == OFS_LASTCMD || paddr == OFS_ERRCNT;

   // ==========================================================
   // next state
   always_comb
   begin
      st_nxt         = st_r;
      st_nxt.cmd_stb = 1'b0;

      // comparator inputs: three stages, taken once stages 2 and 3 agree
      st_nxt.up_s = {st_r.up_s[1:0], upstream_bus_pin_high};
      st_nxt.dn_s = {st_r.dn_s[1:0], downstream_bus_pin_high};
      if (st_r.up_s[1] == st_r.up_s[2])
      begin
         st_nxt.up_f = st_r.up_s[2];
      end
      if (st_r.dn_s[1] == st_r.dn_s[2])
      begin
         st_nxt.dn_f = st_r.dn_s[2];
      end

      // full duplex shifting of command in and response out
      if (frame_start)
      begin
         st_nxt.nbits = 5'h00;
         st_nxt.rx_sh = 20'h00000;
         // a reverse-init answer is never put on a short word
         st_nxt.tx_on = st_r.pend_valid
                        && (frame_long || !st_r.pend_long_only); // RULE7 RULE24
         st_nxt.tx_sh = frame_long ? st_r.pend
                                   : {st_r.pend[11:0], 8'h00}; // RULE7
         st_nxt.pend_valid = 1'b0;
      end
      else if (bit_strobe)
      begin
         st_nxt.rx_sh = {st_r.rx_sh[18:0], rx_bit}; // RULE6
         st_nxt.tx_sh = {st_r.tx_sh[18:0], 1'b0}; // RULE6
         if (st_r.nbits != 5'h1F)
         begin
            st_nxt.nbits = st_r.nbits + 5'h01;
         end
      end
      else if (frame_end)
      begin
         st_nxt.tx_on = 1'b0;
      end

      // fault test on the side that is still inactive
      if (test_done)
      begin
         st_nxt.tst  = TST_IDLE;
         st_nxt.bf   = st_r.tside ? st_r.up_f : st_r.dn_f; // RULE15
         st_nxt.sw   = !(st_r.tside ? st_r.up_f : st_r.dn_f); // RULE17
      end
      else if (st_r.tst == TST_RUN)
      begin
         st_nxt.tcnt = st_r.tcnt + 16'h0001;
      end

      if (bad_frame)
      begin
         // nothing is answered in the frame after a bad one
         st_nxt.pend_valid = 1'b0; // RULE9
         st_nxt.err_cnt    = st_r.err_cnt + 16'h0001;
      end
      else if (good_frame)
      begin
         st_nxt.last_cmd   = st_r.rx_sh;
         st_nxt.pend_valid = 1'b0;
      end

      if (global_hit)
      begin
         // permit and switch bits are dropped, switch stays open
         st_nxt.addr   = GLOBAL_ADDR; // RULE20
         st_nxt.nv     = 1'b0; // RULE21
         st_nxt.bs     = 1'b0; // RULE21
         st_nxt.sw     = 1'b0; // RULE20
         st_nxt.gzero  = 1'b1; // RULE22
         st_nxt.locked = 1'b1; // RULE23
      end
      else if (init_hit)
      begin
         st_nxt.addr   = f_pa;
         st_nxt.nv     = f_data[7];
         st_nxt.bs     = f_data[6];
         st_nxt.locked = 1'b1; // RULE25
         if (f_data[6] && st_r.ctrl_loop)
         begin
            st_nxt.sw = 1'b1; // RULE19
         end
         else if (f_data[6])
         begin
            st_nxt.tst   = TST_RUN; // RULE14
            st_nxt.tcnt  = 16'h0000;
            st_nxt.tside = f_cmd == CMD_RINIT; // RULE18
         end
         st_nxt.pend           = resp_word;
         st_nxt.pend_valid     = 1'b1; // RULE7
         st_nxt.pend_long_only = f_cmd == CMD_RINIT; // RULE24
      end
      else if (other_hit)
      begin
         // executed by the function blocks; address zero stays silent
         st_nxt.cmd_stb  = 1'b1; // RULE22
         st_nxt.cmd_code = f_cmd;
         st_nxt.cmd_data = f_data;
      end

      // clear from the bus or from software returns the init, test and switch state to power-up values
      if (clear_hit || (apb_wr && paddr == OFS_CTRL
                        && pwdata[CTRL_CLR_BIT]))
      begin
         st_nxt.tst        = TST_IDLE;
         st_nxt.tcnt       = 16'h0000;
         st_nxt.addr       = GLOBAL_ADDR;
         st_nxt.nv         = 1'b0;
         st_nxt.bs         = 1'b0;
         st_nxt.bf         = 1'b0;
         st_nxt.sw         = 1'b0;
         st_nxt.locked     = 1'b0; // RULE23 RULE25
         st_nxt.gzero      = 1'b0;
         st_nxt.pend_valid = 1'b0;
      end

      // register bus: read data captured in setup, used in access
      if (apb_setup)
      begin
         unique case (paddr)
            OFS_CTRL:    st_nxt.prdata = {30'h0, st_r.ctrl_loop,
                                          st_r.ctrl_en};
            OFS_STATUS:  st_nxt.prdata = {21'h0, st_r.tst == TST_RUN,
                                          st_r.gzero, st_r.locked,
                                          st_r.sw, st_r.bf, st_r.bs,
                                          st_r.nv, st_r.addr};
            OFS_LASTCMD: st_nxt.prdata = {12'h0, st_r.last_cmd};
            OFS_ERRCNT:  st_nxt.prdata = {16'h0, st_r.err_cnt};
            default:     st_nxt.prdata = 32'h0;
         endcase
      end
      if (apb_wr && paddr == OFS_CTRL)
      begin
         st_nxt.ctrl_en   = pwdata[CTRL_EN_BIT];
         st_nxt.ctrl_loop = pwdata[CTRL_LOOP_BIT];
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r           <= '0;
         st_r.tst       <= TST_IDLE;
         st_r.ctrl_en   <= CTRL_EN_RST;
         st_r.ctrl_loop <= CTRL_LOOP_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign prdata                 = st_r.prdata;
   assign pready                 = psel && penable;
   assign pslverr                = psel && penable && !addr_ok;
   assign tx_bit                 = st_r.tx_on && st_r.tx_sh[19]; // RULE6
   assign tx_en                  = st_r.tx_on;
   assign upstream_pulldown_en   = st_r.tst == TST_RUN && st_r.tside;
   assign downstream_pulldown_en = st_r.tst == TST_RUN && !st_r.tside;
   assign bus_switch_close       = st_r.sw;
   assign bus_fault_flag         = st_r.bf;
   assign nvm_write_permit       = st_r.nv;
   assign programmed_bus_address = st_r.addr;
   assign cmd_strobe             = st_r.cmd_stb;
   assign cmd_code               = st_r.cmd_code;
   assign cmd_data               = st_r.cmd_data;

   // ==========================================================
   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // helper: length of the running fault test
   logic [15:0] run_len;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_len <= 16'h0000;
      end
      else
      begin
         run_len <= (st_r.tst == TST_RUN) ? run_len + 16'h0001 : 16'h0000;
      end
   end

   sequence s_test_ends;
      $fell(st_r.tst == TST_RUN);
   endsequence

   sequence s_init_taken;
      init_hit && !global_hit && f_data[6] && !st_r.ctrl_loop;
   endsequence

   chk_test_length: assert property ( // RULE16
      s_test_ends |-> run_len == 16'(TEST_CYCLES))
      else $error("fault test length wrong");

   chk_switch_cause: assert property ( // RULE17
      $rose(bus_switch_close) && !st_r.ctrl_loop |->
         $past(test_done) && !bus_fault_flag)
      else $error("switch closed without a clean test");

   chk_test_side: assert property ( // RULE18
      s_init_taken |=> (upstream_pulldown_en == ($past(f_cmd) == CMD_RINIT))
                       && (upstream_pulldown_en ^ downstream_pulldown_en))
      else $error("fault test on wrong side");

   chk_loop_no_test: assert property ( // RULE19
      init_hit && st_r.ctrl_loop && f_data[6] && !global_hit |=>
         !upstream_pulldown_en && !downstream_pulldown_en
         && bus_switch_close)
      else $error("test ran in loop-back chain");

   chk_global_open: assert property ( // RULE20
      global_hit |=> programmed_bus_address == GLOBAL_ADDR
                     && !bus_switch_close && !nvm_write_permit)
      else $error("global init left switch or address wrong");

   // helper: a corrupted frame was seen and the next frame not yet begun
   logic bad_armed;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bad_armed <= 1'b0;
      end
      else
      begin
         bad_armed <= bad_frame || (bad_armed && !frame_start);
      end
   end

   chk_bad_mute: assert property ( // RULE9
      bad_armed && frame_start |=> !tx_en)
      else $error("answer sent after corrupted frame");

   chk_short_rinit: assert property ( // RULE24
      frame_start && !frame_long && st_r.pend_long_only |=> !tx_en)
      else $error("short answer to reverse init");

   chk_zero_silent: assert property ( // RULE22
      other_hit && st_r.gzero |=> !st_r.pend_valid && cmd_strobe)
      else $error("node at address zero answered");

   chk_lock_holds: assert property ( // RULE25
      st_r.locked && good_frame && is_init && !clear_hit |=>
         $stable(programmed_bus_address))
      else $error("locked node took a new init");

   chk_resp_fields: assert property ( // RULE2
      init_hit && !global_hit |=> st_r.pend[9:8] == 2'h0
                                  && st_r.pend[11] == $past(f_data[7]))
      else $error("response field wrong");

   chk_duplex_out: assert property ( // RULE6
      tx_en && bit_strobe && !frame_start |=>
         tx_bit == ($past(st_r.tx_sh[18]) && tx_en))
      else $error("response bit out of step");

endmodule

/* File: tb/bus_master_model.sv */
// bus master model: frames command words, collects node responses
// assumes the node samples rx_bit on bit_strobe and answers on tx_bit
`timescale 1ns/1ps
module bus_master_model
(
   input  wire logic pclk,
   output logic      frame_start,
   output logic      frame_long,
   output logic      bit_strobe,
   output logic      rx_bit,
   output logic      frame_end,
   input  wire logic tx_bit,
   input  wire logic tx_en
);
   import sensor_node_pkg::*;

   initial
   begin
      {frame_start, frame_long, bit_strobe, rx_bit, frame_end} = '0;
   end

   // ==========================================================
   // check code, msb first from the seed
   function automatic logic [3:0] crc4(input logic [15:0] d, input int n);
      logic [3:0] c;
      c = CRC_SEED;
      for (int i = n - 1; i >= 0; i--)
         c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? CRC_POLY : 4'h0);
      return c;
   endfunction

   // ==========================================================
   // one word out while the node's word comes back
   task automatic xfer(input logic [15:0] body, input logic lng,
                       input logic bad, output logic [19:0] resp,
                       output logic drove);
      logic [19:0] w;
      w = lng ? {body, crc4(body, 16)} : {8'h00, body[7:0], crc4(body, 8)};
      w[0] = w[0] ^ bad;
      resp = '0;
      drove = 1'b0;
      frame_long <= lng;
      frame_start <= 1'b1;
      @(posedge pclk);
      frame_start <= 1'b0;
      @(posedge pclk);
      for (int i = (lng ? 19 : 11); i >= 0; i--)
      begin
         @(negedge pclk);
         resp[i] = tx_bit;
         drove = drove | tx_en;
         @(posedge pclk);
         rx_bit <= w[i];
         bit_strobe <= 1'b1;
         @(posedge pclk);
         bit_strobe <= 1'b0;
         // released line: show the inverse, never a stale level
         rx_bit <= ~w[i];
         @(posedge pclk);
      end
      frame_end <= 1'b1;
      @(posedge pclk);
      frame_end <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
endmodule

/* File: tb/sensor_bus_slave_init_fault_tb.sv */
// self-checking bench for the sensor bus node: registers over apb,
// bus words through the master model, comparator pins driven here
// assumes sensor_node_pkg, sensor_node and bus_master_model compiled
`timescale 1ns/1ps
module sensor_bus_slave_init_fault_tb;
   import sensor_node_pkg::*;
   // short fault test keeps the run small
   localparam int TC = 20;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, cmd_data;
   logic [31:0] pwdata, prdata, rdat;
   logic        frame_start, frame_long, bit_strobe, rx_bit, frame_end;
   logic        tx_bit, tx_en, up_high, dn_high, up_pd, dn_pd, sw, bf, nv;
   logic        cmd_strobe, rerr, drove, up_seen, dn_seen, st_seen;
   logic [3:0]  addr, cmd_code;
   logic [19:0] resp;
   int          failures, n_checks;

   sensor_node #(.TEST_CYCLES(TC)) dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .frame_start(frame_start),
      .frame_long(frame_long), .bit_strobe(bit_strobe), .rx_bit(rx_bit),
      .frame_end(frame_end), .tx_bit(tx_bit), .tx_en(tx_en),
      .upstream_bus_pin_high(up_high), .downstream_bus_pin_high(dn_high),
      .upstream_pulldown_en(up_pd), .downstream_pulldown_en(dn_pd),
      .bus_switch_close(sw), .bus_fault_flag(bf), .nvm_write_permit(nv),
      .programmed_bus_address(addr), .cmd_strobe(cmd_strobe),
      .cmd_code(cmd_code), .cmd_data(cmd_data)
   );

   bus_master_model master
   (
      .pclk(pclk), .frame_start(frame_start), .frame_long(frame_long),
      .bit_strobe(bit_strobe), .rx_bit(rx_bit), .frame_end(frame_end),
      .tx_bit(tx_bit), .tx_en(tx_en)
   );

   initial pclk = 1'b0;
   always #4 pclk = ~pclk;

   // pulses are collected off the sampling edge
   always @(negedge pclk)
   begin
      up_seen |= up_pd;
      dn_seen |= dn_pd;
      st_seen |= cmd_strobe;
   end

   // ==========================================================
   // shared tasks
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic word(input logic [15:0] b, input logic lng = 1'b1,
                       input logic bad = 1'b0);
      {up_seen, dn_seen, st_seen} = '0;
      master.xfer(b, lng, bad, resp, drove);
   endtask

   task automatic settle();
      repeat (TC + 10) @(posedge pclk);
   endtask

   task automatic soft_clear();
      apb(1'b1, OFS_CTRL, 32'h00000005);
      repeat (2) @(posedge pclk);
   endtask

   function automatic logic [15:0] rinit(input logic nvb, input logic bsb,
      input logic [3:0] pa, input logic [3:0] a,
      input logic [3:0] cmd = CMD_RINIT);
      return {nvb, bsb, 2'b00, pa, a, cmd};
   endfunction

   function automatic logic [19:0] rsp(input logic [3:0] a, input logic b,
                                       input logic n, input logic s);
      logic [15:0] h;
      h = {a, 3'b000, b, n, s, 2'b00, a};
      return {h, master.crc4(h, 16)};
   endfunction

   // ==========================================================
   // scenarios
   task automatic t_regs();
      apb(1'b0, OFS_CTRL, 32'h0);
      check("ctrl reset", rdat, 32'h00000001);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("status reset", rdat, 32'h00000000);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped err", rerr, 1'b1);
      check("unmapped data", rdat, 32'h00000000);
   endtask

   task automatic t_rinit();
      word(rinit(1'b1, 1'b1, 4'h5, 4'h0));
      check("no early reply", drove, 1'b0);
      settle();
      check("up pulldown", up_seen, 1'b1);
      check("down pulldown", dn_seen, 1'b0);
      check("switch", sw, 1'b1);
      check("fault flag", bf, 1'b0);
      check("address", addr, 4'h5);
      check("nvm permit", nv, 1'b1);
      word({8'h00, 4'h5, 4'h5});
      check("reply on", drove, 1'b1);
      check("reply", resp, rsp(4'h5, 1'b0, 1'b1, 1'b1));
      word(rinit(1'b0, 1'b1, 4'h7, 4'h5));
      settle();
      check("retest", up_seen, 1'b0);
      check("locked address", addr, 4'h5);
      soft_clear();
      check("cleared switch", sw, 1'b0);
   endtask

   task automatic t_fault();
      up_high <= 1'b1;
      word(rinit(1'b0, 1'b1, 4'h2, 4'h0));
      settle();
      check("fault pulldown", up_seen, 1'b1);
      check("fault switch", sw, 1'b0);
      check("fault flag set", bf, 1'b1);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("fault status", rdat, 32'h00000162);
      up_high <= 1'b0;
      soft_clear();
   endtask

   task automatic t_forward();
      word(rinit(1'b0, 1'b1, 4'h4, 4'h0, CMD_INIT));
      settle();
      check("fwd down test", dn_seen, 1'b1);
      check("fwd up test", up_seen, 1'b0);
      check("fwd switch", sw, 1'b1);
      soft_clear();
   endtask

   task automatic t_loop();
      apb(1'b1, OFS_CTRL, 32'h00000003);
      word(rinit(1'b0, 1'b1, 4'h6, 4'h0));
      settle();
      check("loop no test", up_seen | dn_seen, 1'b0);
      check("loop switch", sw, 1'b1);
      soft_clear();
   endtask

   task automatic t_corrupt();
      word(rinit(1'b0, 1'b0, 4'h3, 4'h0), 1'b1, 1'b1);
      word(rinit(1'b0, 1'b0, 4'h3, 4'h0));
      check("bad init mute", drove, 1'b0);
      word({8'h00, 4'h3, 4'h5}, 1'b1, 1'b1);
      check("before bad", resp, rsp(4'h3, 1'b0, 1'b0, 1'b0));
      word({8'h00, 4'h3, 4'h5});
      check("after bad", drove, 1'b0);
      apb(1'b0, OFS_ERRCNT, 32'h0);
      check("bad count", rdat, 32'h00000002);
      word({8'h00, 4'h6, 4'h5}, 1'b0);
      soft_clear();
      word(rinit(1'b0, 1'b0, 4'h6, 4'h0));
      word({8'h00, 4'h6, 4'h5}, 1'b0);
      check("short reply", drove, 1'b0);
      soft_clear();
   endtask

   task automatic t_global();
      word(rinit(1'b1, 1'b1, 4'h0, 4'h0));
      settle();
      check("global test", up_seen, 1'b0);
      check("global switch", sw, 1'b0);
      check("global nvm", nv, 1'b0);
      word({8'hA7, 4'h0, 4'h5});
      check("global silent", drove, 1'b0);
      check("global strobe", st_seen, 1'b1);
      check("global code", cmd_code, 4'h5);
      check("global data", cmd_data, 8'hA7);
      word(rinit(1'b0, 1'b0, 4'h4, 4'h0));
      check("global lock", addr, 4'h0);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("global status", rdat & 32'h00000200, 32'h00000200);
   endtask

   // ==========================================================
   // run control
   task automatic stop_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      {psel, penable, pwrite, up_high, dn_high, presetn} = '0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (10) @(posedge pclk);
      t_regs();
      t_corrupt();
      t_rinit();
      t_fault();
      t_forward();
      t_loop();
      t_global();
      stop_test();
   end

   // 16 words of about 70 cycles each fit well inside this span
   initial
   begin
      repeat (20000) @(posedge pclk);
      failures++;
      stop_test();
   end
endmodule
